// *** core/ois_params.svh ***
// constants for the octal input serial shifter
`ifndef OIS_PARAMS_SVH
`define OIS_PARAMS_SVH

// =====================================================================
// shift register shape
`define OIS_STAGES 8
`define OIS_LAST_STAGE 7
`define OIS_STAGE_RST 8'h00
`define OIS_CHAIN_RST 1'b0

// =====================================================================
// shift event buffer
`define OIS_FIFO_WIDTH 1
`define OIS_FIFO_DEPTH 32
`define OIS_FIFO_AW 5

// =====================================================================
// helper counter for the eight-shift check
`define OIS_SHIFTS_OUT 4'h8
`define OIS_SHIFT_CNT_MAX 4'h9

`endif

// *** core/ois_pkg.sv ***
// types for the octal input serial shifter
`default_nettype none

package ois_pkg;
    // what the shift register does in a given cycle
    typedef enum logic [1:0] {
        OIS_HOLD,
        OIS_LOAD,
        OIS_SHIFT
    } ois_mode_t;
endpackage : ois_pkg

`default_nettype wire

// *** core/ois_fifo.sv ***
// flip-flop fifo with valid/ready on both sides and a synchronous flush
`default_nettype none

module ois_fifo
    import ois_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // =================================================================
    // storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    // handshakes; full and empty come straight from the count
    wire logic push = in_valid && in_ready && !flush;
    wire logic pop = out_valid && out_ready && !flush;
    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];

    // pointer and count update, frozen while ce is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
                if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
                count <= count + (AW+1)'(push) - (AW+1)'(pop);
            end
        end
    end

    // data words need no reset; they are only read once written
    always_ff @(posedge clk) begin
        if (ce && push) mem[wr_ptr] <= in_data;
    end

    // =================================================================
    // checks
    property p_no_overflow;
        @(posedge clk) disable iff (!rst_n)
        (count == (AW+1)'(DEPTH)) |-> !in_ready;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo accepts while full");

    cover_fifo_backlog: cover property (@(posedge clk) disable iff (!rst_n) count > (AW+1)'(1));
endmodule : ois_fifo

`default_nettype wire

// *** core/ois_shifter.sv ***
// octal parallel-in serial-out shifter with capture strobe, shift gate and chain input
`default_nettype none
`include "ois_params.svh"

module ois_shifter
    import ois_pkg::*;
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic CE,
    input wire logic PARALLEL_CAPTURE_N,
    input wire logic SHIFT_GATE_N,
    input wire logic SERIAL_CLK,
    input wire logic CHAIN_IN,
    input wire logic [`OIS_LAST_STAGE:0] FIELD_INPUT,
    output logic CHAIN_OUT
);
    // =================================================================
    // helpers
    function automatic logic rise(input logic prev, input logic cur);
        rise = !prev && cur;
    endfunction : rise

    // =================================================================
    // pin synchronisers: every pin is asynchronous to CLK
    logic [`OIS_LAST_STAGE+4:0] sync1;
    logic [`OIS_LAST_STAGE+4:0] sync2;
    logic sclk_prev;

    // idle reset values, so no false strobe or serial edge follows reset
    // ce low freezes the samplers too, so a pin pulse inside a freeze is lost
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1 <= {4'hf, `OIS_STAGE_RST};
            sync2 <= {4'hf, `OIS_STAGE_RST};
        end else if (CE) begin
            sync1 <= {PARALLEL_CAPTURE_N, SHIFT_GATE_N, SERIAL_CLK, CHAIN_IN, FIELD_INPUT};
            sync2 <= sync1;
        end
    end

    // named views of the second stage only
    wire logic capture_n_s = sync2[`OIS_LAST_STAGE+4];
    wire logic gate_n_s = sync2[`OIS_LAST_STAGE+3];
    wire logic sclk_s = sync2[`OIS_LAST_STAGE+2];
    wire logic chain_in_s = sync2[`OIS_LAST_STAGE+1];
    wire logic [`OIS_LAST_STAGE:0] field_s = sync2[`OIS_LAST_STAGE:0];

    // edge finder for the serial clock
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) sclk_prev <= 1'b1;
        else if (CE) sclk_prev <= sclk_s;
    end

    // =================================================================
    // shift request decode
    wire logic capture_active = !capture_n_s;
    wire logic sclk_rise = rise(sclk_prev, sclk_s);
    // gate must be low and capture off for an edge to count
    wire logic shift_req = sclk_rise && !gate_n_s && !capture_active;

    // =================================================================
    // event register feeding the buffer; it holds while the buffer is full
    logic evt_valid;
    logic evt_bit;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_data;
    // limitation: a shift that lands while a held event waits for room replaces it
    wire logic next_evt_valid = !capture_active && (shift_req || (evt_valid && !fifo_in_ready));

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            evt_valid <= 1'b0;
            evt_bit <= `OIS_CHAIN_RST;
        end else if (CE) begin
            evt_valid <= next_evt_valid;
            if (shift_req) evt_bit <= chain_in_s; // chain level taken at the edge
        end
    end

    // drain stalls during capture; a capture also flushes stale shifts
    wire logic drain_ready = !capture_active;
    wire logic pop = fifo_out_valid && drain_ready;

    // 32 deep is far more than a pin-sampled serial clock can fill; it only absorbs stalls
    ois_fifo #(
        .WIDTH(`OIS_FIFO_WIDTH),
        .DEPTH(`OIS_FIFO_DEPTH),
        .AW(`OIS_FIFO_AW)
    ) u_fifo (
        .clk(CLK),
        .rst_n(RSTN),
        .ce(CE),
        .flush(capture_active),
        .in_valid(evt_valid),
        .in_ready(fifo_in_ready),
        .in_data(evt_bit),
        .out_valid(fifo_out_valid),
        .out_ready(drain_ready),
        .out_data(fifo_out_data)
    );

    // =================================================================
    // shift register
    logic [`OIS_LAST_STAGE:0] stage;
    ois_mode_t mode;
    logic [`OIS_LAST_STAGE:0] next_stage;

    // capture first, then a queued shift, else hold
    assign mode = capture_active ? OIS_LOAD : (pop ? OIS_SHIFT : OIS_HOLD);

    always_comb begin
        case (mode)
            OIS_LOAD: next_stage = field_s;
            OIS_SHIFT: next_stage = {stage[`OIS_LAST_STAGE-1:0], fifo_out_data};
            OIS_HOLD: next_stage = stage;
            default: next_stage = stage;
        endcase
    end

    // stages move only on ce, like every other flop here
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) stage <= `OIS_STAGE_RST;
        else if (CE) stage <= next_stage;
    end

    // the last stage is the pin, no extra flop, so no extra lag
    // the far side samples it on its own serial edge, long after it settles
    assign CHAIN_OUT = stage[`OIS_LAST_STAGE];

    // =================================================================
    // helper state for the eight-shift check, read only by assertions
    // saturates at nine so a long chain never wraps back to eight
    logic [3:0] shift_cnt;
    logic first_bit;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            shift_cnt <= `OIS_SHIFT_CNT_MAX;
            first_bit <= 1'b0;
        end else if (CE) begin
            if (capture_active) shift_cnt <= 4'h0;
            else if (pop && shift_cnt != `OIS_SHIFT_CNT_MAX) shift_cnt <= shift_cnt + 4'h1;
            if (!capture_active && pop && shift_cnt == 4'h0) first_bit <= fifo_out_data;
        end
    end

    // =================================================================
    // checks
    // every check samples on CLK; reset masks them all
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    property p_load;
        CE && capture_active |=> stage == $past(field_s);
    endproperty
    a_load: assert property (p_load) else $error("capture did not load field inputs");

    property p_isolate;
        CE && !capture_active && !fifo_out_valid |=> $stable(stage);
    endproperty
    a_isolate: assert property (p_isolate) else $error("stages changed without capture or shift");

    property p_gate;
        CE && sclk_rise && gate_n_s && !evt_valid |=> !evt_valid;
    endproperty
    a_gate: assert property (p_gate) else $error("shift queued with gate high");

    property p_edge;
        CE && sclk_rise && !gate_n_s && !capture_active |=> evt_valid && evt_bit == $past(chain_in_s);
    endproperty
    a_edge: assert property (p_edge) else $error("qualified edge did not queue a shift");

    property p_eight;
        shift_cnt == `OIS_SHIFTS_OUT |-> CHAIN_OUT == first_bit;
    endproperty
    a_eight: assert property (p_eight) else $error("chain input not at output after eight shifts");

    property p_shift;
        CE && pop |=> stage == {$past(stage[`OIS_LAST_STAGE-1:0]), $past(fifo_out_data)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift moved stages wrongly");

    property p_reach;
        CE && shift_req && !evt_valid && !fifo_out_valid ##1 CE && !capture_active ##1 CE && !capture_active
            |=> stage[0] == $past(chain_in_s, 3);
    endproperty
    a_reach: assert property (p_reach) else $error("queued shift did not reach the first stage");

    property p_priority;
        CE && capture_active |=> !evt_valid ##0 !fifo_out_valid;
    endproperty
    a_priority: assert property (p_priority) else $error("shift survived a capture");

    property p_hold;
        CE && !capture_active && gate_n_s && sclk_rise && !evt_valid && !fifo_out_valid
            |=> $stable(stage) ##1 !fifo_out_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("stages moved with gate high");

    property p_out;
        CE && capture_active |=> CHAIN_OUT == $past(field_s[`OIS_LAST_STAGE]);
    endproperty
    a_out: assert property (p_out) else $error("chain output not last captured stage");

    cover_capture_release: cover property (capture_active ##1 !capture_active);
    cover_eight_shifts: cover property (shift_cnt == `OIS_SHIFTS_OUT);
    cover_gated_edge: cover property (sclk_rise && gate_n_s && !capture_active);
    cover_chain_reached: cover property (shift_cnt == `OIS_SHIFTS_OUT ##1 pop);
endmodule : ois_shifter

`default_nettype wire

// *** core/ois_fifo_unused.sv ***
// intentionally empty
`default_nettype none
`default_nettype wire

// *** verification/ois_host.sv ***
// host model: capture strobe, shift gate, serial clock and chain data
`default_nettype none

module ois_host #(
    parameter int DEVICES = 1
) (
    input wire logic clk,
    input wire logic chain_out,
    output logic serial_clk,
    output logic shift_gate_n,
    output logic capture_n,
    output logic chain_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================================
    // frame shape
    // eight bits per device; a cascade just lengthens the frame
    localparam int FRAME_BITS = 8 * DEVICES;

    // serial clock stands still low outside frames
    initial begin
        serial_clk = 1'b0;
        shift_gate_n = 1'b1;
        capture_n = 1'b1;
        chain_in = 1'b0;
    end

    // =====================================================================
    // capture: strobe low for len cycles, then settle time for the syncs
    task automatic capture(input int len);
        @(posedge clk);
        capture_n <= 1'b0;
        repeat (len) @(posedge clk);
        capture_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : capture

    // one serial bit, 320 ns period: four cycles low, four high
    // gate and data lead the rise by a cycle so the syncs see them no later
    task automatic shift(input logic gate_n, input logic din, output logic seen);
        @(posedge clk);
        shift_gate_n <= gate_n;
        chain_in <= din;
        @(posedge clk);
        serial_clk <= 1'b1;
        repeat (4) @(posedge clk);
        serial_clk <= 1'b0;
        repeat (2) @(posedge clk);
        // the answer lands five cycles after the rise; read it one cycle later
        seen = chain_out;
    endtask : shift
endmodule : ois_host

`default_nettype wire

// *** verification/octal_input_serial_shifter_tb.sv ***
// self-checking bench for the octal input serial shifter
`default_nettype none

module octal_input_serial_shifter_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] field = 8'h00;
    wire sclk;
    wire gate_n;
    wire cap_n;
    wire cin;
    wire cout;
    logic [7:0] m;
    logic [3:0] q;
    logic ref_q[$];
    logic b;
    logic s;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    // =====================================================================
    // clock, design and host
    always #20 clk = ~clk;

    ois_shifter dut (.CLK(clk), .RSTN(rstn), .CE(ce), .PARALLEL_CAPTURE_N(cap_n),
        .SHIFT_GATE_N(gate_n), .SERIAL_CLK(sclk), .CHAIN_IN(cin), .FIELD_INPUT(field),
        .CHAIN_OUT(cout));

    ois_host u_host (.clk(clk), .chain_out(cout), .serial_clk(sclk), .shift_gate_n(gate_n),
        .capture_n(cap_n), .chain_in(cin));

    // =====================================================================
    // compare, verdict and hang guard
    task automatic check(input string what, input logic exp, input logic seen);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // whole run is under a thousand cycles; four thousand means a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // =====================================================================
    // tests; ref_q models the chain, its front faces the chain output
    initial begin
        void'($urandom(32'h98ea));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);

        // capture random bytes, then shift past the byte into chain data
        for (int r = 0; r < 4; r++) begin
            m = 8'($urandom);
            field <= m;
            u_host.capture(4);
            ref_q.delete();
            for (int j = 7; j >= 0; j--) begin
                ref_q.push_back(m[j]);
            end
            check("capture", ref_q[0], cout);
            // field flips after release and must not reach the stages
            field <= ~m;
            for (int i = 0; i < u_host.FRAME_BITS + 4; i++) begin
                b = 1'($urandom);
                u_host.shift(1'b0, b, s);
                void'(ref_q.pop_front());
                ref_q.push_back(b);
                check("shift", ref_q[0], s);
            end
        end
        $display("test capture_shift done");

        // gate high: serial edges must not move anything
        m = 8'ha5;
        field <= m;
        u_host.capture(4);
        for (int i = 0; i < 3; i++) begin
            u_host.shift(1'b1, 1'b0, s);
            check("gated", m[7], s);
        end
        $display("test gate_off done");

        // serial edge inside a capture is lost; bits 7 and 6 differ to show it
        m = 8'h5a;
        field <= m;
        fork
            u_host.capture(6);
            u_host.shift(1'b0, 1'b1, s);
        join
        check("capture_wins", m[7], cout);
        u_host.shift(1'b0, 1'b1, s);
        check("shift_after", m[6], s);
        $display("test capture_priority done");

        // ce low freezes everything: a strobe inside the freeze must not load zeros
        ce <= 1'b0;
        field <= 8'h00;
        u_host.capture(4);
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        check("frozen", m[6], cout);
        u_host.shift(1'b0, 1'b0, s);
        check("thawed", m[5], s);
        $display("test clock_enable done");

        // paralleled twins: the host merges each pair of bits into one reading
        q = 4'($urandom);
        field <= {q[3], q[3], q[2], q[2], q[1], q[1], q[0], q[0]};
        u_host.capture(4);
        s = cout;
        for (int k = 3; k >= 0; k--) begin
            b = s;
            u_host.shift(1'b0, 1'b0, s);
            check("paired_and", q[k], b & s);
            check("paired_or", q[k], b | s);
            if (k > 0) begin
                u_host.shift(1'b0, 1'b0, s);
            end
        end
        $display("test paired_channels done");

        end_of_test();
    end
endmodule : octal_input_serial_shifter_tb

`default_nettype wire
